// ### src/interface_ecc_generator.sv
`timescale 1ns/1ps
`include "ecc_gen_params.svh"
module interface_ecc_generator
    import ecc_gen_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic code_block_size_select,
    input wire logic code_restart_write,
    input wire logic master_byte_valid,
    input wire logic [7:0] master_byte,
    input wire logic fifo_byte_valid,
    input wire logic [7:0] fifo_byte,
    output logic [23:0] first_code_result_ff,
    output logic [23:0] second_code_result_ff,
    output logic code_done_ff
)
;
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Byte source and block position
    // ------------------------------------------------------------
    // Interface is byte-wide only; word transfers would break the count
    // Either interface feeds
    logic byte_en;
    logic [7:0] byte_in;
    assign byte_en = master_byte_valid | fifo_byte_valid;
    assign byte_in = master_byte_valid ? master_byte : fifo_byte;

    ecc_state_t state_ff;
    ecc_state_t nxt_state;
    logic mode_ff;
    logic [8:0] index_ff;
    logic [8:0] nxt_index;
    logic active;
    logic last_byte;
    assign active = (state_ff != ST_DONE) & byte_en & ~code_restart_write;
    assign last_byte = mode_ff ? (index_ff == 9'(`BLK_LARGE - 1))
                               : (index_ff[7:0] == 8'(`BLK_SMALL - 1));
    assign nxt_index = last_byte ? 9'h000 : 9'(index_ff + 9'h001);

    // ------------------------------------------------------------
    // Parity accumulator
    // ------------------------------------------------------------
    logic [17:0] line_par;
    logic [5:0] col_par;
    logic acc_clr;
    assign acc_clr = code_restart_write | (active & last_byte);
    ecc_parity_acc #(.AW(9)) u_acc (
        .mclk(mclk),
        .rst_n(rst_n_ff),
        .clr(acc_clr),
        .byte_en(active),
        .byte_in(byte_in),
        .index(index_ff),
        .line_par_ff(line_par),
        .col_par_ff(col_par)
    );

    // Final byte is folded in here, since the accumulator clears at once
    logic row_par;
    logic [17:0] fin_line;
    logic [5:0] fin_col;
    logic [23:0] code_word;
    assign row_par = ^byte_in;
    generate
        for (genvar i = 0; i < 9; i++)
        begin : g_fin
            assign fin_line[2*i] = line_par[2*i] ^ (row_par & ~index_ff[i]);
            assign fin_line[2*i+1] = line_par[2*i+1] ^ (row_par & index_ff[i]);
        end
    endgenerate
    assign fin_col[0] = col_par[0] ^ ^{byte_in[6], byte_in[4],
                                       byte_in[2], byte_in[0]};
    assign fin_col[1] = col_par[1] ^ ^{byte_in[7], byte_in[5],
                                       byte_in[3], byte_in[1]};
    assign fin_col[2] = col_par[2] ^ ^{byte_in[5], byte_in[4],
                                       byte_in[1], byte_in[0]};
    assign fin_col[3] = col_par[3] ^ ^{byte_in[7], byte_in[6],
                                       byte_in[3], byte_in[2]};
    assign fin_col[4] = col_par[4] ^ ^byte_in[3:0];
    assign fin_col[5] = col_par[5] ^ ^byte_in[7:4];
    // Inverted, spare bits one
    // Large blocks keep line pairs 0 to 7, small blocks pairs 0 to 6; the pairs above read as ones
    assign code_word = mode_ff
        ? {~fin_col, `UNUSED_BITS, ~fin_line[15:0]}
        : {~fin_col, `UNUSED_BITS, `UNUSED_BITS, ~fin_line[13:0]};

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    logic store_first;
    logic store_second;
    // Large block also to first result
    assign store_first = active & last_byte & (state_ff == ST_FIRST);
    assign store_second = active & last_byte & (state_ff == ST_SECOND);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_FIRST:
                if (store_first)
                    nxt_state = mode_ff ? ST_DONE : ST_SECOND;
            ST_SECOND:
                if (store_second)
                    nxt_state = ST_DONE;
            ST_DONE:
                nxt_state = ST_DONE;
            default:
                nxt_state = ST_FIRST;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            state_ff <= ST_FIRST;
            index_ff <= 9'h000;
            mode_ff <= 1'b0;
        end
        else if (code_restart_write)
        begin
            state_ff <= ST_FIRST;
            index_ff <= 9'h000;
            mode_ff <= code_block_size_select;
        end
        else if (active)
        begin
            state_ff <= nxt_state;
            index_ff <= nxt_index;
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    // Codes held across restart; only done clears
    always_ff @(posedge mclk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            first_code_result_ff <= `CODE_IDLE;
            second_code_result_ff <= `CODE_IDLE;
            code_done_ff <= 1'b0;
        end
        else if (code_restart_write)
        begin
            code_done_ff <= 1'b0;
        end
        else
        begin
            if (store_first)
                first_code_result_ff <= code_word;
            if (store_second)
                second_code_result_ff <= code_word;
            if (nxt_state == ST_DONE && active)
                code_done_ff <= 1'b1;
        end
    end
endmodule

// ### src/ecc_gen_params.svh
`ifndef ECC_GEN_PARAMS_SVH
`define ECC_GEN_PARAMS_SVH
// Operation
// - Codes are computed on bytes crossing the master or FIFO interface, no copy.
// - With block size select low, two 3-byte codes each cover 256 bytes.
// - With block size select high, one 3-byte code covers 512 bytes.
// - The code drops the top index pair, so bytes n and n+128 (n+256 in 512-byte mode) give the same error syndrome.
// - Any restart write begins a new calculation at the next byte.
// - In 256-byte mode the first 256 bytes go to the first result.
// - In 256-byte mode the next 256 bytes go to the second result.
// - In 256-byte mode both results freeze after the second code.
// - In 512-byte mode the first result holds the code, the second is unused.
// - In 512-byte mode the first result freezes once complete.
`define BLK_SMALL 512'd256
`define BLK_LARGE 512'd512
`define CODE_IDLE 24'hffffff
`define UNUSED_BITS 2'b11
`endif

// ### src/ecc_gen_pkg.sv
package ecc_gen_pkg;
    typedef enum logic [1:0]
    {
        ST_FIRST = 2'b00,
        ST_SECOND = 2'b01,
        ST_DONE = 2'b11
    } ecc_state_t;
endpackage

// ### src/ecc_parity_acc.sv
`timescale 1ns/1ps
`include "ecc_gen_params.svh"
module ecc_parity_acc #(
    parameter int AW = 9
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic byte_en,
    input wire logic [7:0] byte_in,
    input wire logic [AW-1:0] index,
    output logic [2*AW-1:0] line_par_ff,
    output logic [5:0] col_par_ff
)
;
    // ------------------------------------------------------------
    // Parity accumulation
    // ------------------------------------------------------------
    logic row_par;
    logic [2*AW-1:0] line_mask;
    logic [5:0] col_byte;
    assign row_par = ^byte_in;
    // Even bit of each pair takes index bit low, odd bit takes it high
    generate
        for (genvar i = 0; i < AW; i++)
        begin : g_line
            assign line_mask[2*i] = row_par & ~index[i];
            assign line_mask[2*i+1] = row_par & index[i];
        end
    endgenerate
    assign col_byte[0] = ^{byte_in[6], byte_in[4], byte_in[2], byte_in[0]};
    assign col_byte[1] = ^{byte_in[7], byte_in[5], byte_in[3], byte_in[1]};
    assign col_byte[2] = ^{byte_in[5], byte_in[4], byte_in[1], byte_in[0]};
    assign col_byte[3] = ^{byte_in[7], byte_in[6], byte_in[3], byte_in[2]};
    assign col_byte[4] = ^byte_in[3:0];
    assign col_byte[5] = ^byte_in[7:4];
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_par_ff <= '0;
            col_par_ff <= '0;
        end
        else if (clr)
        begin
            line_par_ff <= '0;
            col_par_ff <= '0;
        end
        else if (byte_en)
        begin
            line_par_ff <= line_par_ff ^ line_mask;
            col_par_ff <= col_par_ff ^ col_byte;
        end
    end
endmodule

// ### testbench/ecc_gen_chk.sv
`timescale 1ns/1ps
module ecc_gen_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic code_block_size_select,
    input wire logic code_restart_write,
    input wire logic master_byte_valid,
    input wire logic fifo_byte_valid,
    input wire logic [23:0] first_code_result_ff,
    input wire logic [23:0] second_code_result_ff,
    input wire logic code_done_ff
);
    logic mode_ff;
    logic [9:0] cnt_ff;
    wire [47:0] codes = {first_code_result_ff, second_code_result_ff};
    wire any = master_byte_valid | fifo_byte_valid;
    wire hold = code_done_ff & ~code_restart_write;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            {mode_ff, cnt_ff} <= 11'h0;
        else if (code_restart_write)
            {mode_ff, cnt_ff} <= {code_block_size_select, 10'h0};
        else
            cnt_ff <= cnt_ff + 10'(any & ~code_done_ff);
    a_restart_clears: assert property
        (code_restart_write |=> !code_done_ff) else $error("done kept");
    a_restart_keeps: assert property
        (code_restart_write |=> $stable(codes)) else $error("codes moved");
    a_done_sticks: assert property
        (hold |=> code_done_ff) else $error("done lost");
    a_codes_frozen: assert property
        (hold |=> $stable(codes)) else $error("codes not frozen");
    a_idle_keeps: assert property
        (!any |=> $stable(codes)) else $error("codes moved idle");
    a_done_count: assert property
        ($rose(code_done_ff) |-> cnt_ff == 10'h200) else $error("done count");
    a_first_point: assert property
        ($changed(first_code_result_ff) |-> cnt_ff == {mode_ff, ~mode_ff, 8'h0})
        else $error("first moved");
    a_second_point: assert property
        ($changed(second_code_result_ff) |-> !mode_ff && cnt_ff == 10'h200)
        else $error("second moved");
    c_two_codes: cover property ($rose(code_done_ff) && !mode_ff);
    c_one_code: cover property ($rose(code_done_ff) && mode_ff);
    c_both_ports: cover property (master_byte_valid && fifo_byte_valid);
endmodule
bind interface_ecc_generator ecc_gen_chk u_chk (.*);

// ### testbench/byte_source.sv
`timescale 1ns/1ps
module byte_source (
    input wire logic mclk,
    output logic master_byte_valid,
    output logic [7:0] master_byte,
    output logic fifo_byte_valid,
    output logic [7:0] fifo_byte
);
    // one byte per strobe, unused lane inverted
    task automatic drive(input logic [7:0] d, input logic [1:0] s);
        master_byte_valid = !s[0];
        fifo_byte_valid = ^s;
        master_byte = s[0] ? ~d : d;
        fifo_byte = s == 2'h1 ? d : ~d;
        @(posedge mclk);
        #1;
    endtask
endmodule

// ### testbench/interface_ecc_generator_test.sv
`timescale 1ns/1ps
module interface_ecc_generator_test;
    logic mclk, nrst, code_block_size_select, code_restart_write;
    logic master_byte_valid, fifo_byte_valid, code_done_ff;
    logic [7:0] master_byte, fifo_byte, d;
    logic [23:0] first_code_result_ff, second_code_result_ff, e1, e2;
    logic [31:0] seed = 32'h0001843d;
    logic [17:0] lp;
    logic [5:0] cp;
    int mismatches, tests_run;
    interface_ecc_generator DUT (.*);
    byte_source src (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [23:0] code(input logic m);
        return m ? {~cp, 2'h3, ~lp[15:0]} : {~cp, 4'hf, ~lp[13:0]};
    endfunction
    task automatic chk(input logic [23:0] e, s, input string w);
        tests_run++;
        mismatches += int'(s !== e);
        if (s !== e)
            $display("mismatch %s exp %h got %h", w, e, s);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic run(input logic m, input int total);
        code_block_size_select = m;
        code_restart_write = 1'b1;
        src.drive(8'h5a, 2'h2);
        code_restart_write = 1'b0;
        {e1, e2, lp, cp} = {first_code_result_ff, second_code_result_ff, 24'h0};
        for (int n = 0; n < total; n++)
        begin
            d = 8'(rnd());
            for (int i = 0; i < 9; i++)
                lp[2*i+n[i]] ^= ^d;
            for (int c = 0; c < 24; c++)
                cp[2*(c%3)+(c/3>>c%3)%2] ^= d[c/3];
            src.drive(d, 2'(rnd() % 3));
            if (n == 255 && !m)
                e1 = code(1'b0);
            if (n == 511)
                {e1, e2} = m ? {code(1'b1), e2} : {e1, ~(code(1'b0) ^ e1)};
            if (n == 255 || n == 511 || n == total - 1)
            begin
                chk(e1, first_code_result_ff, "first");
                chk(e2, second_code_result_ff, "second");
            end
            if (rnd() % 4 == 0)
                src.drive(8'(rnd()), 2'h3);
        end
        chk(24'(total > 511), 24'(code_done_ff), "done");
        $display("test end mode %0d bytes %0d", m, total);
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial
    begin
        {nrst, code_block_size_select, code_restart_write} = 3'h0;
        repeat (6) src.drive(8'(rnd()), 2'h3);
        nrst = 1'b1;
        repeat (5) src.drive(8'(rnd()), 2'h3);
        run(1'b0, 520);
        run(1'b1, 300);
        run(1'b1, 600);
        run(1'b0, 300);
        run(1'b0, 520);
        summarize();
    end
    initial
    begin
        repeat (9000) @(posedge mclk);
        mismatches++;
        summarize();
    end
endmodule
